// [core/isr_pkg.sv]
// Package of constants for the instrument status reporting block.
package isr_pkg;
   // ---------------------------------------------------------------
   // Questionable-data bit positions
   // ---------------------------------------------------------------
   localparam int QD_VOLT_BIT  = 0;
   localparam int QD_CURR_BIT  = 1;
   localparam int QD_OHMS_BIT  = 9;
   localparam int QD_LIMLO_BIT = 11;
   localparam int QD_LIMHI_BIT = 12;
   localparam logic [15:0] QD_USED_MASK = 16'h1A03;
   // ---------------------------------------------------------------
   // Standard event and status byte bit positions
   // ---------------------------------------------------------------
   localparam int SE_OPC_BIT   = 0;
   localparam int SE_PON_BIT   = 7;
   localparam logic [7:0] SE_USED_MASK = 8'hBD;
   localparam int SB_QUES_BIT  = 3;
   localparam int SB_MAV_BIT   = 4;
   localparam int SB_ESB_BIT   = 5;
   localparam int SB_RQS_BIT   = 6;
   // ---------------------------------------------------------------
   // Reset values and sizes
   // ---------------------------------------------------------------
   localparam logic [15:0] QD_RESET   = 16'h0000;
   localparam logic [7:0]  MASK_RESET = 8'h00;
   localparam int ERR_DEPTH   = 20;
   localparam int ERR_CHARS   = 80;
   localparam logic [7:0] OPC_REPLY = 8'h31;
   // ---------------------------------------------------------------
   // Query selector codes
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      ISR_Q_QENA = 4'h0,
      ISR_Q_QEVT = 4'h1,
      ISR_Q_ESR  = 4'h2,
      ISR_Q_ESE  = 4'h3,
      ISR_Q_SRE  = 4'h4,
      ISR_Q_STB  = 4'h5,
      ISR_Q_PSC  = 4'h6,
      ISR_Q_OPC  = 4'h7
   } isr_query_t;
endpackage

// [core/isr_err_queue.sv]
// First-in first-out queue of error codes with message lengths.
`timescale 1ns/10ps
module isr_err_queue #(
   parameter int DEPTH = isr_pkg::ERR_DEPTH,
   parameter int WIDTH = 16,
   parameter int LEN_W = 7
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             clr,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] push_code,
   input  wire logic [LEN_W-1:0] push_len,
   input  wire logic             pop,
   output logic      [WIDTH-1:0] pop_code,
   output logic      [LEN_W-1:0] pop_len,
   output logic                  empty,
   output logic                  full
);
   localparam int AW = $clog2(DEPTH + 1);

   // Elaboration check: the shifting head needs at least two entries.
   if (DEPTH < 2) begin : g_depth_chk
      $error("Error queue depth too small.");
   end

   logic [WIDTH-1:0] code_ff [DEPTH];
   logic [LEN_W-1:0] len_ff  [DEPTH];
   logic [WIDTH-1:0] nxt_code [DEPTH];
   logic [LEN_W-1:0] nxt_len  [DEPTH];
   logic [AW-1:0]    cnt_ff;
   logic [AW-1:0]    nxt_cnt;
   logic             do_pop;
   logic             do_push;

   assign empty    = (cnt_ff == '0);
   assign full     = (cnt_ff == AW'(DEPTH));
   assign pop_code = code_ff[0];
   assign pop_len  = len_ff[0];

   // Shift register: head at index 0, a pop shifts all entries down.
   always_comb begin
      do_pop  = pop && !empty;
      do_push = push && (!full || do_pop);
      nxt_cnt = cnt_ff;
      for (int i = 0; i < DEPTH; i++) begin
         nxt_code[i] = code_ff[i];
         nxt_len[i]  = len_ff[i];
      end
      if (do_pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            nxt_code[i] = code_ff[i+1];
            nxt_len[i]  = len_ff[i+1];
         end
      end
      if (do_push) begin
         nxt_code[AW'(nxt_cnt - AW'(do_pop))] = push_code;
         nxt_len[AW'(nxt_cnt - AW'(do_pop))]  = push_len;
      end
      nxt_cnt = AW'(cnt_ff + AW'(do_push) - AW'(do_pop));
      if (clr) begin
         nxt_cnt = '0;
      end
   end

   // Registers of the queue.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            code_ff[i] <= '0;
            len_ff[i]  <= '0;
         end
      end else begin
         cnt_ff <= nxt_cnt;
         for (int i = 0; i < DEPTH; i++) begin
            code_ff[i] <= nxt_code[i];
            len_ff[i]  <= nxt_len[i];
         end
      end
   end
endmodule // isr_err_queue

// [core/isr_status.sv]
// Status reporting registers, queries and error queue of the instrument.
// Functional notes
// - Voltage-type range overload sets questionable bit of weight 1.
// - Current range overload sets questionable bit of weight 2.
// - Resistance range overload sets questionable bit of weight 512.
// - Reading below lower limit during limit test sets weight 2048.
// - Reading above upper limit during limit test sets weight 4096.
// - Questionable events ANDed with mask, ORed into summary bit.
// - Questionable events clear on clear-status and after event query.
// - Questionable mask clears on preset, write of zero, power-on.
// - Error queue holds up to 20 entries, read first-in first-out.
// - Stored error message length is limited to 80 characters.
// - Questionable mask query returns weighted sum of mask bits.
// - Questionable event query returns weighted sum of event bits.
// - Standard event query returns weighted sum of event bits.
// - Clear-status clears summary and event registers, not masks.
// - Operation-complete command sets event bit 0 after finishing.
// - Operation-complete query answers character 1 once executed.
// - Power-on clear 1 clears standard event and status byte masks; 0 restores both from storage.
// - Power-on clear query returns stored setting, 0 or 1.
// - Standard event mask selects bits feeding event summary bit.
// - Status byte mask selects bits that raise a service request.
// - Both mask queries return the weighted sum of set bits.
// - Status byte query equals serial poll, keeps bit 6, in order.
// - Serial poll clears only the request-service bit.
// - Power cycle sets standard event bit 7 until read or cleared.
// - Message-available bit 4 stays set until response fully read.
`timescale 1ns/10ps
module isr_status #(
   parameter int ERR_W = 16
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             ovl_volt,
   input  wire logic             ovl_curr,
   input  wire logic             ovl_ohms,
   input  wire logic             lim_active,
   input  wire logic             lim_low,
   input  wire logic             lim_high,
   input  wire logic [7:0]       std_evt_in,
   input  wire logic             cmd_cls,
   input  wire logic             cmd_preset,
   input  wire logic             cmd_opc_done,
   input  wire logic             wr_qena,
   input  wire logic             wr_ese,
   input  wire logic             wr_sre,
   input  wire logic             wr_psc,
   input  wire logic [15:0]      wr_data,
   input  wire logic             nv_psc,
   input  wire logic [7:0]       nv_ese,
   input  wire logic [7:0]       nv_sre,
   input  wire logic             qry_valid,
   input  wire logic [3:0]       qry_sel,
   input  wire logic             out_pending,
   input  wire logic             serial_poll,
   input  wire logic             err_push,
   input  wire logic [ERR_W-1:0] err_code,
   input  wire logic [6:0]       err_len,
   input  wire logic             err_pop,
   output logic                  rsp_valid,
   output logic      [15:0]      rsp_data,
   output logic      [7:0]       poll_byte,
   output logic                  srq,
   output logic                  psc_out,
   output logic      [7:0]       ese_out,
   output logic      [7:0]       sre_out,
   output logic      [ERR_W-1:0] err_head_code,
   output logic      [6:0]       err_head_len,
   output logic                  err_empty,
   output logic                  err_full
);
   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rst_sync1_ff;
   logic rst_sync2_ff;
   logic rst_n;

   // Two-stage release of the asynchronous reset.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync1_ff <= 1'b0;
         rst_sync2_ff <= 1'b0;
      end else begin
         rst_sync1_ff <= 1'b1;
         rst_sync2_ff <= rst_sync1_ff;
      end
   end
   assign rst_n = rst_sync2_ff;

   // ---------------------------------------------------------------
   // State registers
   // ---------------------------------------------------------------
   logic [15:0] qevt_ff, nxt_qevt;
   logic [15:0] qena_ff, nxt_qena;
   logic [7:0]  esr_ff,  nxt_esr;
   logic [7:0]  ese_ff,  nxt_ese;
   logic [7:0]  sre_ff,  nxt_sre;
   logic        psc_ff,  nxt_psc;
   logic        rqs_ff,  nxt_rqs;
   logic        pon_ff,  nxt_pon;
   logic        rsp_v_ff, nxt_rsp_v;
   logic [15:0] rsp_d_ff, nxt_rsp_d;
   logic [15:0] qset;
   logic        ques_sum;
   logic        esb_sum;
   logic [7:0]  stb;
   logic        rqs_cond;
   logic        rd_qevt;
   logic        rd_esr;

   // Combine an event register with its mask into one summary bit.
   function automatic logic summ16(input logic [15:0] e,
                                   input logic [15:0] m);
      return |(e & m);
   endfunction

   // ---------------------------------------------------------------
   // Summary bits and status byte
   // ---------------------------------------------------------------
   // Questionable-data event sources.
   always_comb begin
      qset = 16'h0000;
      qset[isr_pkg::QD_VOLT_BIT]  = ovl_volt;
      qset[isr_pkg::QD_CURR_BIT]  = ovl_curr;
      qset[isr_pkg::QD_OHMS_BIT]  = ovl_ohms;
      qset[isr_pkg::QD_LIMLO_BIT] = lim_active & lim_low;
      qset[isr_pkg::QD_LIMHI_BIT] = lim_active & lim_high;
   end

   // Summary bits feeding the status byte.
   always_comb begin
      ques_sum = summ16(qevt_ff, qena_ff & isr_pkg::QD_USED_MASK);
      esb_sum  = summ16({8'h00, esr_ff}, {8'h00, ese_ff});
      stb      = 8'h00;
      stb[isr_pkg::SB_QUES_BIT] = ques_sum;
      stb[isr_pkg::SB_MAV_BIT]  = out_pending;
      stb[isr_pkg::SB_ESB_BIT]  = esb_sum;
      rqs_cond = |(stb & sre_ff & ~(8'h01 << isr_pkg::SB_RQS_BIT));
      stb[isr_pkg::SB_RQS_BIT]  = rqs_ff;
   end

   // ---------------------------------------------------------------
   // Next state of the status registers
   // ---------------------------------------------------------------
   // Event and mask registers; a new event wins over a clear.
   always_comb begin
      rd_qevt   = qry_valid && (qry_sel == 4'(isr_pkg::ISR_Q_QEVT));
      rd_esr    = qry_valid && (qry_sel == 4'(isr_pkg::ISR_Q_ESR));
      nxt_qevt  = qevt_ff;
      nxt_qena  = qena_ff;
      nxt_esr   = esr_ff;
      nxt_ese   = ese_ff;
      nxt_sre   = sre_ff;
      nxt_psc   = psc_ff;
      nxt_rqs   = rqs_ff;
      nxt_pon   = 1'b0;
      // clear on status clear or read
      if (cmd_cls || rd_qevt) begin
         nxt_qevt = isr_pkg::QD_RESET;
      end
      nxt_qevt = nxt_qevt | (qset & isr_pkg::QD_USED_MASK);
      if (cmd_cls || rd_esr) begin
         nxt_esr = 8'h00;
      end
      if (cmd_opc_done) begin
         nxt_esr[isr_pkg::SE_OPC_BIT] = 1'b1;
      end
      if (pon_ff) begin
         nxt_esr[isr_pkg::SE_PON_BIT] = 1'b1;
      end
      nxt_esr = nxt_esr | (std_evt_in & isr_pkg::SE_USED_MASK);
      if (cmd_preset) begin
         nxt_qena = isr_pkg::QD_RESET;
      end else if (wr_qena) begin
         nxt_qena = wr_data & isr_pkg::QD_USED_MASK;
      end
      if (wr_ese) begin
         nxt_ese = wr_data[7:0];
      end
      if (wr_sre) begin
         nxt_sre = wr_data[7:0] & ~(8'h01 << isr_pkg::SB_RQS_BIT);
      end
      if (wr_psc) begin
         nxt_psc = wr_data[0];
      end
      if (serial_poll || cmd_cls) begin
         nxt_rqs = 1'b0;
      end
      if (rqs_cond && !rqs_ff && !serial_poll && !cmd_cls) begin
         nxt_rqs = 1'b1;
      end
      if (pon_ff) begin
         nxt_psc  = nv_psc;
         nxt_ese  = nv_psc ? isr_pkg::MASK_RESET : nv_ese;
         nxt_sre  = nv_psc ? isr_pkg::MASK_RESET :
                    (nv_sre & ~(8'h01 << isr_pkg::SB_RQS_BIT));
         nxt_qena = isr_pkg::QD_RESET;
         nxt_rqs  = 1'b0;
      end
   end

   // Registers of the status state; the power-on cycle ignores writes.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         qevt_ff <= isr_pkg::QD_RESET;
         qena_ff <= isr_pkg::QD_RESET;
         esr_ff  <= isr_pkg::MASK_RESET;
         ese_ff  <= isr_pkg::MASK_RESET;
         sre_ff  <= isr_pkg::MASK_RESET;
         psc_ff  <= 1'b1;
         rqs_ff  <= 1'b0;
         pon_ff  <= 1'b1;
      end else begin
         qevt_ff <= nxt_qevt;
         qena_ff <= nxt_qena;
         esr_ff  <= nxt_esr;
         ese_ff  <= nxt_ese;
         sre_ff  <= nxt_sre;
         psc_ff  <= nxt_psc;
         rqs_ff  <= nxt_rqs;
         pon_ff  <= nxt_pon;
      end
   end

   // ---------------------------------------------------------------
   // Query responses
   // ---------------------------------------------------------------
   // Response word for each query, registered one cycle later.
   always_comb begin
      nxt_rsp_v = qry_valid;
      nxt_rsp_d = rsp_d_ff;
      if (qry_valid) begin
         unique case (qry_sel)
            4'(isr_pkg::ISR_Q_QENA): nxt_rsp_d = qena_ff;
            4'(isr_pkg::ISR_Q_QEVT): nxt_rsp_d = qevt_ff;
            4'(isr_pkg::ISR_Q_ESR):  nxt_rsp_d = {8'h00, esr_ff};
            4'(isr_pkg::ISR_Q_ESE):  nxt_rsp_d = {8'h00, ese_ff};
            4'(isr_pkg::ISR_Q_SRE):  nxt_rsp_d = {8'h00, sre_ff};
            4'(isr_pkg::ISR_Q_STB):  nxt_rsp_d = {8'h00, stb};
            4'(isr_pkg::ISR_Q_PSC):  nxt_rsp_d = {15'h0000, psc_ff};
            4'(isr_pkg::ISR_Q_OPC):  nxt_rsp_d = {8'h00, isr_pkg::OPC_REPLY};
            default:                 nxt_rsp_d = 16'h0000;
         endcase
      end
   end

   // Registers of the response.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_v_ff <= 1'b0;
         rsp_d_ff <= 16'h0000;
      end else begin
         rsp_v_ff <= nxt_rsp_v;
         rsp_d_ff <= nxt_rsp_d;
      end
   end

   // ---------------------------------------------------------------
   // Error queue
   // ---------------------------------------------------------------
   logic [6:0] err_len_lim;

   assign err_len_lim = (err_len > 7'(isr_pkg::ERR_CHARS)) ?
                        7'(isr_pkg::ERR_CHARS) : err_len;

   isr_err_queue #(
      .DEPTH (isr_pkg::ERR_DEPTH),
      .WIDTH (ERR_W),
      .LEN_W (7)
   ) u_errq (
      .clk       (clk),
      .rst_n     (rst_n),
      .clr       (cmd_cls),
      .push      (err_push),
      .push_code (err_code),
      .push_len  (err_len_lim),
      .pop       (err_pop),
      .pop_code  (err_head_code),
      .pop_len   (err_head_len),
      .empty     (err_empty),
      .full      (err_full)
   );

   // Outputs.
   assign rsp_valid = rsp_v_ff;
   assign rsp_data  = rsp_d_ff;
   assign poll_byte = stb;
   assign srq       = rqs_ff;
   assign psc_out   = psc_ff;
   assign ese_out   = ese_ff;
   assign sre_out   = sre_ff;
endmodule // isr_status

// [tb/isr_monitor.sv]
// Concurrent checks on the ports of the status reporting block.
`timescale 1ns/10ps
module isr_monitor (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        qry_valid,
   input wire logic [3:0]  qry_sel,
   input wire logic        serial_poll,
   input wire logic        cmd_cls,
   input wire logic        out_pending,
   input wire logic        rsp_valid,
   input wire logic [15:0] rsp_data,
   input wire logic [7:0]  poll_byte,
   input wire logic        srq,
   input wire logic        psc_out,
   input wire logic [7:0]  ese_out,
   input wire logic [7:0]  sre_out,
   input wire logic [6:0]  err_head_len,
   input wire logic        err_empty,
   input wire logic        err_full
);
   // All checks use the block clock and sleep while reset is low.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_qry_answer: assert property (qry_valid |=> rsp_valid)
      else $error("query got no answer");
   a_rsp_single: assert property (!qry_valid |=> !rsp_valid)
      else $error("answer without query");
   a_opc_reply: assert property (qry_valid && qry_sel == 4'h7
      |=> rsp_data == isr_pkg::OPC_REPLY) else $error("bad opc reply");
   a_psc_reply: assert property (qry_valid && qry_sel == 4'h6
      |=> rsp_data == {15'h0000, $past(psc_out)}) else $error("bad psc");
   a_ese_reply: assert property (qry_valid && qry_sel == 4'h3
      |=> rsp_data == {8'h00, $past(ese_out)}) else $error("bad ese");
   a_sre_reply: assert property (qry_valid && qry_sel == 4'h4
      |=> rsp_data == {8'h00, $past(sre_out)}) else $error("bad sre");
   a_stb_same: assert property (qry_valid && qry_sel == 4'h5
      |=> rsp_data == {8'h00, $past(poll_byte)}) else $error("bad stb");
   a_stb_keeps: assert property (qry_valid && srq && !serial_poll
      && !cmd_cls |=> srq) else $error("query cleared service request");
   a_poll_clear: assert property (serial_poll |=> !srq)
      else $error("serial poll left service request");
   a_rqs_rise: assert property (|(poll_byte & sre_out & 8'hBF)
      && !serial_poll && !cmd_cls |=> srq) else $error("no request");
   a_srq_cause: assert property (!srq
      && !(|(poll_byte & sre_out & 8'hBF)) |=> !srq)
      else $error("request without enabled summary");
   a_mav_level: assert property (poll_byte[4] == out_pending)
      else $error("message bit wrong");
   a_err_flags: assert property (!(err_empty && err_full))
      else $error("queue empty and full");
   a_len_limit: assert property (!err_empty |-> err_head_len <= 7'h50)
      else $error("message length above limit");
   // Main scenarios seen.
   c_stb_query: cover property (qry_valid && qry_sel == 4'h5 && srq);
   c_poll: cover property (serial_poll && srq);
   c_full: cover property (err_full);
endmodule // isr_monitor

bind isr_status isr_monitor u_mon (.*);

// [tb/isr_host.sv]
// Remote bus controller model issuing commands and queries.
`timescale 1ns/10ps
module isr_host (
   input  wire logic        clk,
   input  wire logic        rsp_valid,
   input  wire logic [15:0] rsp_data,
   output logic             qry_valid,
   output logic [3:0]       qry_sel,
   output logic             wr_qena,
   output logic             wr_ese,
   output logic             wr_sre,
   output logic             wr_psc,
   output logic             cmd_cls,
   output logic             cmd_preset,
   output logic             cmd_opc_done,
   output logic             serial_poll,
   output logic [15:0]      wr_data
);
   // Idle bus at time zero.
   initial begin
      qry_valid = 1'b0;
      qry_sel = 4'h0;
      wr_data = 16'h0000;
      {serial_poll, cmd_opc_done, cmd_preset, cmd_cls} = 4'h0;
      {wr_psc, wr_sre, wr_ese, wr_qena} = 4'h0;
   end
   // One query; the answer is taken one cycle after it is issued.
   task automatic query(input logic [3:0] s, output logic [15:0] d,
                        output logic ok);
      @(negedge clk);
      qry_valid = 1'b1;
      qry_sel = s;
      @(negedge clk);
      qry_valid = 1'b0;
      ok = rsp_valid;
      d = rsp_data;
   endtask
   // One-cycle strobe: 0..2 mask writes, 3 psc write, 4 clear, 5 preset, 6 opc, 7 poll.
   task automatic strobe(input int k, input logic [15:0] x);
      @(negedge clk);
      {serial_poll, cmd_opc_done, cmd_preset, cmd_cls,
       wr_psc, wr_sre, wr_ese, wr_qena} = 8'h01 << k;
      wr_data = x;
      @(negedge clk);
      {serial_poll, cmd_opc_done, cmd_preset, cmd_cls,
       wr_psc, wr_sre, wr_ese, wr_qena} = 8'h00;
   endtask
endmodule // isr_host

// [tb/isr_status_tb.sv]
// Self-checking bench of the status reporting block.
`timescale 1ns/10ps
module isr_status_tb;
   logic        clk, rst_b, ovl_volt, ovl_curr, ovl_ohms, lim_active;
   logic        lim_low, lim_high, nv_psc, out_pending, err_push, err_pop;
   logic        qry_valid, wr_qena, wr_ese, wr_sre, wr_psc, cmd_cls, ok;
   logic        cmd_preset, cmd_opc_done, serial_poll, rsp_valid, srq;
   logic        psc_out, err_empty, err_full;
   logic [3:0]  qry_sel;
   logic [6:0]  err_len, err_head_len;
   logic [7:0]  std_evt_in, nv_ese, nv_sre, poll_byte, ese_out, sre_out;
   logic [15:0] wr_data, rsp_data, err_code, err_head_code, d, v;
   int          num_errors, n_compared, qevt, qena, esr, ese, sre, psc;
   int          codes[$], lens[$];

   isr_status dut (.*);
   isr_host   host (.*);

   // Block clock of 5 ns.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic qchk(input logic [3:0] s, input int e);
      host.query(s, d, ok);
      chk({15'h0000, ok}, 16'h0001);
      chk(d, e[15:0]);
      if (s == 4'h1) qevt = 0;
      if (s == 4'h2) esr = 0;
   endtask
   task automatic cmd(input int k, input int x);
      host.strobe(k, x[15:0]);
      case (k)
         0: qena = x;
         1: ese = x;
         2: sre = x & 8'hBF;
         3: psc = x & 1;
         4: begin
            qevt = 0;
            esr = 0;
         end
         5: qena = 0;
         6: esr = esr | 1;
         default: ;
      endcase
   endtask
   function automatic int wgt(input logic [4:0] o);
      return (o[0] ? 1 : 0) + (o[1] ? 2 : 0) + (o[2] ? 512 : 0)
         + (o[3] && lim_active ? 2048 : 0) + (o[4] && lim_active ? 4096 : 0);
   endfunction
   // Measurement side event pulse; model follows.
   task automatic evt(input logic [4:0] o, input logic [7:0] s);
      @(negedge clk);
      {lim_high, lim_low, ovl_ohms, ovl_curr, ovl_volt} = o;
      std_evt_in = s;
      @(negedge clk);
      {lim_high, lim_low, ovl_ohms, ovl_curr, ovl_volt} = 5'h00;
      std_evt_in = 8'h00;
      qevt = qevt | wgt(o);
      esr = esr | (s & 8'hBD);
   endtask
   function automatic logic [7:0] stb_exp(input logic rq);
      return {1'b0, rq, |(esr & ese), out_pending, |(qevt & qena), 3'b000};
   endfunction
   // Reset held 10 cycles, then power-on handling is checked.
   task automatic por(input logic p);
      @(negedge clk);
      rst_b = 1'b0;
      nv_psc = p;
      nv_ese = 8'($urandom) & 8'hBD;
      nv_sre = 8'($urandom) & 8'hBF;
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      repeat (6) @(negedge clk);
      psc = p;
      ese = p ? 0 : nv_ese;
      sre = p ? 0 : nv_sre;
      qena = 0;
      qevt = 0;
      esr = 8'h80;
      chk({8'h00, ese_out}, ese[15:0]);
      chk({8'h00, sre_out}, sre[15:0]);
      chk({15'h0000, psc_out}, psc[15:0]);
   endtask
   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Watchdog well beyond the expected few hundred cycles.
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      $display("[ERR] %0t run timed out", $time);
      end_sim();
   end
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      rst_b = 1'b0;
      {ovl_volt, ovl_curr, ovl_ohms, lim_active, lim_low, lim_high} = 6'h00;
      {nv_psc, out_pending, err_push, err_pop} = 4'h0;
      {std_evt_in, nv_ese, nv_sre, err_len} = 31'h00000000;
      err_code = 16'h0000;
      void'($urandom(32'h2dd4d448));
      por(1'b1);
      qchk(4'h6, 1);
      qchk(4'h2, 8'h80);
      qchk(4'h2, 0);
      $display("test 1 power-on done");
      lim_active = 1'b1;
      for (int i = 0; i < 5; i++) begin
         evt(5'h01 << i, 8'h00);
         qchk(4'h1, qevt);
         qchk(4'h1, 0);
      end
      lim_active = 1'b0;
      evt(5'h18, 8'h00);
      qchk(4'h1, 0);
      $display("test 2 questionable events done");
      v = (16'($urandom) & 16'h1A03) | 16'h0001;
      cmd(0, v);
      qchk(4'h0, v);
      evt(5'h01, 8'h00);
      chk({8'h00, poll_byte}, {8'h00, stb_exp(1'b0)});
      cmd(0, v & 16'hFFFE);
      chk({8'h00, poll_byte}, {8'h00, stb_exp(1'b0)});
      cmd(5, 0);
      qchk(4'h0, 0);
      cmd(0, v);
      cmd(0, 0);
      qchk(4'h0, 0);
      cmd(0, v);
      cmd(4, 0);
      qchk(4'h1, 0);
      qchk(4'h0, v);
      $display("test 3 questionable mask done");
      cmd(1, ($urandom & 8'hBD) | 8'h20);
      qchk(4'h3, ese);
      cmd(2, 8'h20);
      qchk(4'h4, 8'h20);
      evt(5'h00, 8'hFF);
      repeat (2) @(negedge clk);
      chk({15'h0000, srq}, 16'h0001);
      qchk(4'h5, stb_exp(1'b1));
      cmd(7, 0);
      chk({8'h00, poll_byte}, {8'h00, stb_exp(1'b0)});
      qchk(4'h2, 8'hBD);
      cmd(6, 0);
      qchk(4'h2, 1);
      qchk(4'h7, 16'h0031);
      qchk(4'hB, 0);
      evt(5'h00, 8'h04);
      cmd(4, 0);
      qchk(4'h2, 0);
      chk({8'h00, ese_out}, ese[15:0]);
      cmd(3, 0);
      qchk(4'h6, 0);
      $display("test 4 standard events done");
      for (int i = 0; i < 21; i++) begin
         @(negedge clk);
         err_push = 1'b1;
         err_code = 16'($urandom);
         err_len = 7'($urandom);
         if (codes.size() < 20) begin
            codes.push_back(err_code);
            lens.push_back(err_len > 80 ? 80 : err_len);
         end
         @(negedge clk);
         err_push = 1'b0;
      end
      chk({15'h0000, err_full}, 16'h0001);
      while (codes.size() > 0) begin
         chk(err_head_code, 16'(codes.pop_front()));
         chk({9'h000, err_head_len}, 16'(lens.pop_front()));
         @(negedge clk);
         err_pop = 1'b1;
         @(negedge clk);
         err_pop = 1'b0;
         @(negedge clk);
      end
      chk({15'h0000, err_empty}, 16'h0001);
      $display("test 5 error queue done");
      out_pending = 1'b1;
      @(negedge clk);
      chk({15'h0000, poll_byte[4]}, 16'h0001);
      out_pending = 1'b0;
      @(negedge clk);
      chk({15'h0000, poll_byte[4]}, 16'h0000);
      por(1'b0);
      qchk(4'h2, 8'h80);
      qchk(4'h0, 0);
      $display("test 6 message bit and restore done");
      end_sim();
   end
endmodule // isr_status_tb
